// ===== design/dual_element_simd_datapath.sv
// Purpose: Two processing elements with ALU, multiplier, shifter and register file
// Assumes: Sequencer and address generators drive INSTR and transfer requests
// Notes: Register reads see the state before the current edge
// How it works
// - First element always runs, second when enabled
// - SIMD: same instruction, own operands per element
// - SIMD transfers move two values, one each
// - Each element has ALU, multiplier, shifter, file
// - Every compute operation finishes in one cycle
// - Multifunction runs ALU and multiply together
// - Fixed 32, single 32, extended 40 formats
// - Thirty-two registers, sixteen visible per element
// - Register file links units and buses
// - Two 64-bit bus transfers every cycle
// - Primary bank after reset, secondary on mode
`timescale 1ns/100ps
module dual_element_simd_datapath
	import simd_dp_pkg::*;
#(
	parameter int REG_COUNT = 2 * BANK_REGS
) (
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire mode_s MODE_CTRL,
	input wire instr_s INSTR,
	input wire xfer_s PM_XFER,
	input wire logic [BUS_W-1:0] PM_RDATA,
	input wire xfer_s DM_XFER,
	input wire logic [BUS_W-1:0] DM_RDATA,
	output bus_word_s PM_WDATA,
	output bus_word_s DM_WDATA,
	output flags_s FLAGS_FIRST,
	output flags_s FLAGS_SECOND,
	output mode_s ACTIVE_MODE
);
	localparam int IDX_W = $clog2(REG_COUNT);

	// Bank bit plus visible index must cover the file exactly
	if (REG_COUNT != 2 * BANK_REGS) begin : g_bad_count
		$error("REG_COUNT must be two banks of visible registers");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef logic [REG_COUNT-1:0][REG_W-1:0] rfile_t;
	typedef struct packed {
		rfile_t [ELEMENTS-1:0] rf;
		mode_s mode;
		flags_s [ELEMENTS-1:0] flags;
		bus_word_s [BUSES-1:0] wout;
	} state_s;

	state_s st;
	state_s next_st;
	xfer_s [BUSES-1:0] xf;
	logic [BUSES-1:0][BUS_W-1:0] rdat;
	logic [ELEMENTS-1:0][REG_W:0] alu_res;
	logic [ELEMENTS-1:0][REG_W:0] mul_res;

	assign xf = {DM_XFER, PM_XFER};
	assign rdat = {DM_RDATA, PM_RDATA};

	// ----------------------------------------
	// Arithmetic helpers, all single cycle
	// ----------------------------------------
	// Fixed add or subtract on the top 32 bits, overflow in the top bit
	function automatic logic [REG_W:0] fix_addsub(input logic [REG_W-1:0] a,
		input logic [REG_W-1:0] b, input logic sub);
		logic [FIX_W:0] s;
		s = sub ? {a[REG_W-1], a[REG_W-1 -: FIX_W]} - {b[REG_W-1], b[REG_W-1 -: FIX_W]}
			: {a[REG_W-1], a[REG_W-1 -: FIX_W]} + {b[REG_W-1], b[REG_W-1 -: FIX_W]};
		return {s[FIX_W] ^ s[FIX_W-1], s[FIX_W-1:0], {PAD_W{1'b0}}};
	endfunction

	// Float multiply, truncating; zero or underflow flushes to signed zero
	function automatic logic [REG_W:0] fmul(input logic [REG_W-1:0] a,
		input logic [REG_W-1:0] b, input logic ext);
		logic [MAN_W:0] ma;
		logic [MAN_W:0] mb;
		logic [2*MAN_W+1:0] p;
		logic [9:0] e;
		logic [MAN_W-1:0] m;
		logic s;
		ma = {1'b1, a[MAN_W-1:0]};
		mb = {1'b1, b[MAN_W-1:0]};
		p = ma * mb;
		s = a[SIGN_BIT] ^ b[SIGN_BIT];
		e = {2'h0, a[EXP_LSB +: EXP_W]} + {2'h0, b[EXP_LSB +: EXP_W]} - EXP_BIAS
			+ {9'h0, p[2*MAN_W+1]};
		m = p[2*MAN_W+1] ? p[2*MAN_W -: MAN_W] : p[2*MAN_W-1 -: MAN_W];
		m = ext ? m : (m & SINGLE_MASK);
		if (a[EXP_LSB +: EXP_W] == '0 || b[EXP_LSB +: EXP_W] == '0 || e[9] || e == '0)
			return {1'b0, s, {(REG_W-1){1'b0}}};
		if (e >= EXP_MAX)
			return {1'b1, s, EXP_MAX[EXP_W-1:0], {MAN_W{1'b0}}};
		return {1'b0, s, e[EXP_W-1:0], m};
	endfunction

	// Float add; larger magnitude leads, smaller is aligned down
	function automatic logic [REG_W:0] fadd(input logic [REG_W-1:0] a,
		input logic [REG_W-1:0] b, input logic ext);
		logic [REG_W-1:0] x;
		logic [REG_W-1:0] y;
		logic [MAN_W+1:0] mx;
		logic [MAN_W+1:0] sum;
		logic [9:0] e;
		logic [MAN_W-1:0] m;
		x = (a[SIGN_BIT-1:0] >= b[SIGN_BIT-1:0]) ? a : b;
		y = (a[SIGN_BIT-1:0] >= b[SIGN_BIT-1:0]) ? b : a;
		mx = {1'b0, |x[EXP_LSB +: EXP_W], x[MAN_W-1:0]};
		sum = {1'b0, |y[EXP_LSB +: EXP_W], y[MAN_W-1:0]}
			>> (x[EXP_LSB +: EXP_W] - y[EXP_LSB +: EXP_W]);
		sum = (x[SIGN_BIT] == y[SIGN_BIT]) ? mx + sum : mx - sum;
		e = {2'h0, x[EXP_LSB +: EXP_W]};
		if (sum[MAN_W+1]) begin
			sum = sum >> 1;
			e = e + 10'h001;
		end
		// Normalise; stops at exponent zero, which then flushes
		for (int i = 0; i <= MAN_W; i++) begin
			if (!sum[MAN_W] && e != '0) begin
				sum = sum << 1;
				e = e - 10'h001;
			end
		end
		m = ext ? sum[MAN_W-1:0] : (sum[MAN_W-1:0] & SINGLE_MASK);
		if (!sum[MAN_W] || e == '0)
			return {1'b0, x[SIGN_BIT], {(REG_W-1){1'b0}}};
		if (e >= EXP_MAX)
			return {1'b1, x[SIGN_BIT], EXP_MAX[EXP_W-1:0], {MAN_W{1'b0}}};
		return {1'b0, x[SIGN_BIT], e[EXP_W-1:0], m};
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Write order per element: ALU, multiplier, shifter, program bus, data bus
	always_comb begin
		logic simd;
		logic bank;
		logic isfix;
		logic ext;
		logic [REG_W-1:0] oa;
		logic [REG_W-1:0] ob;
		logic [FIX_W-1:0] fc;
		logic signed [2*FIX_W-1:0] prod;
		logic [SH_AMT_W-1:0] amt;
		logic [SH_AMT_W-1:0] mag;
		simd = st.mode.second_element_enable;
		bank = st.mode.secondary_regs_select;
		isfix = INSTR.fmt == FMT_FIXED;
		ext = INSTR.fmt == FMT_EXT;
		oa = '0;
		ob = '0;
		fc = '0;
		prod = '0;
		amt = '0;
		mag = '0;
		alu_res = '0;
		mul_res = '0;
		next_st = st;
		next_st.mode = MODE_CTRL; // Bank and enable act from the next cycle
		for (int e = 0; e < ELEMENTS; e++) begin
			// Second element only joins while enabled
			if (e == 0 || simd) begin
				// Same slots, this element's own file and flags
				oa = st.rf[e][{bank, INSTR.alu.a}];
				ob = st.rf[e][{bank, INSTR.alu.b}];
				case (INSTR.alu.op)
					ALU_ADD: alu_res[e] = isfix ? fix_addsub(oa, ob, 1'b0) : fadd(oa, ob, ext);
					ALU_SUB: alu_res[e] = isfix ? fix_addsub(oa, ob, 1'b1)
						: fadd(oa, {~ob[SIGN_BIT], ob[SIGN_BIT-1:0]}, ext);
					ALU_AND: alu_res[e] = {1'b0, oa & ob};
					ALU_OR: alu_res[e] = {1'b0, oa | ob};
					ALU_XOR: alu_res[e] = {1'b0, oa ^ ob};
					ALU_PASS: alu_res[e] = {1'b0, oa};
					ALU_NEG: alu_res[e] = isfix ? fix_addsub('0, oa, 1'b1)
						: {1'b0, ~oa[SIGN_BIT], oa[SIGN_BIT-1:0]};
					ALU_ABS: alu_res[e] = isfix ? (oa[SIGN_BIT] ? fix_addsub('0, oa, 1'b1)
						: {1'b0, oa}) : {2'b00, oa[SIGN_BIT-1:0]};
					default: alu_res[e] = '0;
				endcase
				// Multiplier beside the ALU, same cycle
				oa = st.rf[e][{bank, INSTR.mul.a}];
				ob = st.rf[e][{bank, INSTR.mul.b}];
				prod = $signed(oa[REG_W-1 -: FIX_W]) * $signed(ob[REG_W-1 -: FIX_W]);
				mul_res[e] = isfix ? {prod[2*FIX_W-1:FIX_W-1] != '0 && prod[2*FIX_W-1:FIX_W-1] != '1,
					prod[FIX_W-1:0], {PAD_W{1'b0}}} : fmul(oa, ob, ext);
				// Shifter on fixed data; negative amount shifts right
				oa = st.rf[e][{bank, INSTR.sh.a}];
				ob = st.rf[e][{bank, INSTR.sh.b}];
				amt = ob[PAD_W +: SH_AMT_W];
				mag = amt[SH_AMT_W-1] ? SH_AMT_W'(-amt) : amt;
				if (!amt[SH_AMT_W-1])
					fc = oa[REG_W-1 -: FIX_W] << mag;
				else if (INSTR.sh.op == SH_ASH)
					fc = FIX_W'($signed(oa[REG_W-1 -: FIX_W]) >>> mag);
				else
					fc = oa[REG_W-1 -: FIX_W] >> mag;
				// Results land in the file by the next edge
				if (INSTR.valid && INSTR.alu.op != ALU_NOP) begin
					next_st.rf[e][{bank, INSTR.alu.dst}] = alu_res[e][REG_W-1:0];
					next_st.flags[e].zero = isfix ? alu_res[e][REG_W-1:0] == '0
						: alu_res[e][SIGN_BIT-1:0] == '0;
					next_st.flags[e].neg = alu_res[e][SIGN_BIT];
					next_st.flags[e].ovf = alu_res[e][REG_W];
				end
				if (INSTR.valid && INSTR.mul.op != MUL_NOP) begin
					next_st.rf[e][{bank, INSTR.mul.dst}] = mul_res[e][REG_W-1:0];
					next_st.flags[e].mul_ovf = mul_res[e][REG_W];
				end
				if (INSTR.valid && INSTR.sh.op != SH_NOP)
					next_st.rf[e][{bank, INSTR.sh.dst}] = {fc, {PAD_W{1'b0}}};
				// Loads: one 32-bit half each in SIMD, else one full value
				for (int b = 0; b < BUSES; b++) begin
					if (xf[b].valid && !xf[b].store)
						next_st.rf[e][{bank, xf[b].idx}] = (e != 0) ?
							{rdat[b][BUS_W-1 -: FIX_W], {PAD_W{1'b0}}} : (simd ?
							{rdat[b][FIX_W-1:0], {PAD_W{1'b0}}} : rdat[b][REG_W-1:0]);
				end
			end
		end
		// Both buses serve a store each cycle
		for (int b = 0; b < BUSES; b++) begin
			next_st.wout[b].valid = xf[b].valid && xf[b].store;
			if (xf[b].valid && xf[b].store)
				next_st.wout[b].data = simd ? {st.rf[1][{bank, xf[b].idx}][REG_W-1 -: FIX_W],
					st.rf[0][{bank, xf[b].idx}][REG_W-1 -: FIX_W]}
					: {{(BUS_W-REG_W){1'b0}}, st.rf[0][{bank, xf[b].idx}]};
		end
	end

	// Whole state in one register; primary bank and single element after reset
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN)
			st <= '0;
		else
			st <= next_st;
	end

	assign PM_WDATA = st.wout[PM_SLOT];
	assign DM_WDATA = st.wout[DM_SLOT];
	assign FLAGS_FIRST = st.flags[0];
	assign FLAGS_SECOND = st.flags[1];
	assign ACTIVE_MODE = st.mode;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [IDX_W-1:0] alu_dst_idx;
	logic [IDX_W-1:0] mul_dst_idx;
	logic [IDX_W-1:0] dm_idx;
	logic [IDX_W-1:0] pm_idx;
	logic simd_now;
	assign alu_dst_idx = {st.mode.secondary_regs_select, INSTR.alu.dst};
	assign mul_dst_idx = {st.mode.secondary_regs_select, INSTR.mul.dst};
	assign dm_idx = {st.mode.secondary_regs_select, DM_XFER.idx};
	assign pm_idx = {st.mode.secondary_regs_select, PM_XFER.idx};
	assign simd_now = st.mode.second_element_enable;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);

	sequence s_mf_issue;
		INSTR.valid && INSTR.alu.op != ALU_NOP && INSTR.mul.op != MUL_NOP
			&& INSTR.alu.dst != INSTR.mul.dst && INSTR.sh.op == SH_NOP
			&& !PM_XFER.valid && !DM_XFER.valid;
	endsequence
	sequence s_dm_load;
		DM_XFER.valid && !DM_XFER.store;
	endsequence

	property p_second_frozen;
		!simd_now |=> $stable(FLAGS_SECOND) && $stable(st.rf[1]);
	endproperty
	a_second_frozen: assert property (p_second_frozen)
		else $error("second element changed while disabled");
	property p_simd_flags;
		simd_now && INSTR.valid && INSTR.alu.op != ALU_NOP |=>
			FLAGS_SECOND.neg == $past(alu_res[1][SIGN_BIT])
			&& FLAGS_FIRST.neg == $past(alu_res[0][SIGN_BIT]);
	endproperty
	a_simd_flags: assert property (p_simd_flags)
		else $error("elements did not both execute");
	property p_dual_load;
		simd_now ##0 s_dm_load |=>
			st.rf[1][$past(dm_idx)] == {$past(DM_RDATA[BUS_W-1 -: FIX_W]), {PAD_W{1'b0}}}
			&& st.rf[0][$past(dm_idx)] == {$past(DM_RDATA[FIX_W-1:0]), {PAD_W{1'b0}}};
	endproperty
	a_dual_load: assert property (p_dual_load)
		else $error("SIMD load did not split two values");
	property p_single_store;
		!simd_now && PM_XFER.valid && PM_XFER.store |=> PM_WDATA.valid
			&& PM_WDATA.data == {{(BUS_W-REG_W){1'b0}}, $past(st.rf[0][pm_idx])};
	endproperty
	a_single_store: assert property (p_single_store)
		else $error("single store carried wrong value");
	property p_mul_one_cycle;
		INSTR.valid && INSTR.mul.op != MUL_NOP && INSTR.sh.op == SH_NOP
			&& !PM_XFER.valid && !DM_XFER.valid
			|=> st.rf[0][$past(mul_dst_idx)] == $past(mul_res[0][REG_W-1:0]);
	endproperty
	a_mul_one_cycle: assert property (p_mul_one_cycle)
		else $error("multiply result late");
	property p_multifunction;
		s_mf_issue |=> st.rf[0][$past(alu_dst_idx)] == $past(alu_res[0][REG_W-1:0])
			&& st.rf[0][$past(mul_dst_idx)] == $past(mul_res[0][REG_W-1:0])
			&& (!$past(simd_now) || st.rf[1][$past(mul_dst_idx)] == $past(mul_res[1][REG_W-1:0]));
	endproperty
	a_multifunction: assert property (p_multifunction)
		else $error("ALU and multiply did not both complete");
	property p_single_fmt;
		INSTR.valid && INSTR.fmt != FMT_EXT && INSTR.mul.op != MUL_NOP |->
			mul_res[0][PAD_W-1:0] == '0;
	endproperty
	a_single_fmt: assert property (p_single_fmt)
		else $error("32-bit product has low bits set");
	property p_dual_store;
		PM_XFER.valid && PM_XFER.store && DM_XFER.valid && DM_XFER.store
			|=> PM_WDATA.valid && DM_WDATA.valid;
	endproperty
	a_dual_store: assert property (p_dual_store)
		else $error("both buses not served in one cycle");
	property p_bank_isolated;
		st.mode.secondary_regs_select && !INSTR.valid && !PM_XFER.valid ##0 s_dm_load |=>
			st.rf[0][{1'b0, $past(DM_XFER.idx)}] == $past(st.rf[0][{1'b0, DM_XFER.idx}]);
	endproperty
	a_bank_isolated: assert property (p_bank_isolated)
		else $error("secondary load touched primary bank");
endmodule

// ===== design/simd_dp_pkg.sv
// Purpose: Shared constants and carrier types for the dual element datapath
// Assumes: One core clock, no software-visible registers in this block
// Notes: A 32-bit value sits in the top 32 bits of a 40-bit register
package simd_dp_pkg;
	// ----------------------------------------
	// Widths and field layout
	// ----------------------------------------
	localparam int REG_W = 40;
	localparam int FIX_W = 32;
	localparam int PAD_W = REG_W - FIX_W;
	localparam int BUS_W = 64;
	localparam int BANK_REGS = 16;
	localparam int ELEMENTS = 2;
	localparam int BUSES = 2;
	localparam int SIGN_BIT = 39;
	localparam int EXP_LSB = 31;
	localparam int EXP_W = 8;
	localparam int MAN_W = 31;
	localparam int SH_AMT_W = 8;
	localparam int PM_SLOT = 0;
	localparam int DM_SLOT = 1;
	localparam logic [9:0] EXP_BIAS = 10'h07f;
	localparam logic [9:0] EXP_MAX = 10'h0ff;
	localparam logic [MAN_W-1:0] SINGLE_MASK = 31'h7fffff00;

	// ----------------------------------------
	// Operation codes
	// ----------------------------------------
	typedef enum logic [3:0] {
		ALU_NOP, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_PASS, ALU_NEG, ALU_ABS
	} alu_op_e;
	typedef enum logic [1:0] {MUL_NOP, MUL_MUL} mul_op_e;
	typedef enum logic [1:0] {SH_NOP, SH_LSH, SH_ASH} sh_op_e;
	typedef enum logic [1:0] {FMT_FIXED, FMT_SINGLE, FMT_EXT} fmt_e;
	typedef logic [3:0] reg_idx_t;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {alu_op_e op; reg_idx_t dst; reg_idx_t a; reg_idx_t b;} alu_slot_s;
	typedef struct packed {mul_op_e op; reg_idx_t dst; reg_idx_t a; reg_idx_t b;} mul_slot_s;
	typedef struct packed {sh_op_e op; reg_idx_t dst; reg_idx_t a; reg_idx_t b;} sh_slot_s;
	typedef struct packed {
		logic valid;
		fmt_e fmt;
		alu_slot_s alu;
		mul_slot_s mul;
		sh_slot_s sh;
	} instr_s;
	typedef struct packed {logic valid; logic store; reg_idx_t idx;} xfer_s;
	typedef struct packed {logic valid; logic [BUS_W-1:0] data;} bus_word_s;
	typedef struct packed {logic second_element_enable; logic secondary_regs_select;} mode_s;
	typedef struct packed {logic zero; logic neg; logic ovf; logic mul_ovf;} flags_s;
	localparam mode_s MODE_RESET = '0;
endpackage

// ===== dv/mem_partner.sv
// Purpose: Memory side of both buses, standing in for the address generators
// Assumes: Word address equals the register index of the request
// Notes: Idle read lines carry a moving pattern so stale data never looks valid
`timescale 1ns/100ps
module mem_partner
	import simd_dp_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire xfer_s pm_x,
	input wire xfer_s dm_x,
	input wire bus_word_s pm_w,
	input wire bus_word_s dm_w,
	output logic [BUS_W-1:0] pm_r,
	output logic [BUS_W-1:0] dm_r
);
	// ----------------------------------------
	// Storage and bus service
	// ----------------------------------------
	logic [BUS_W-1:0] mem [16];
	logic [BUS_W-1:0] junk;
	logic [3:0] pm_sa;
	logic [3:0] dm_sa;

	// Both buses answer in the request cycle
	always_comb begin
		pm_r = (pm_x.valid && !pm_x.store) ? mem[pm_x.idx] : junk;
		dm_r = (dm_x.valid && !dm_x.store) ? mem[dm_x.idx] : ~junk;
	end

	// Store data lands one edge after the request, so the address is kept
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			junk <= 64'h5a5a_0f0f_3c3c_9696;
			pm_sa <= 4'h0;
			dm_sa <= 4'h0;
		end else begin
			junk <= {junk[62:0], ~junk[63]};
			pm_sa <= pm_x.idx;
			dm_sa <= dm_x.idx;
			if (pm_w.valid) mem[pm_sa] <= pm_w.data;
			if (dm_w.valid) mem[dm_sa] <= dm_w.data;
		end
	end
endmodule

// ===== dv/tb.sv
// Purpose: Self-checking bench for the dual element datapath
// Assumes: One stimulus call per clock edge, inputs driven by non-blocking assignment
// Notes: Register contents are only seen through stores, so each test ends with one
`timescale 1ns/100ps
module tb
	import simd_dp_pkg::*;
;
	logic core_clk;
	logic rstn;
	mode_s mode_ctrl;
	mode_s mode_v;
	mode_s active_mode;
	instr_s instr;
	xfer_s pm_xfer;
	xfer_s dm_xfer;
	logic [BUS_W-1:0] pm_rdata;
	logic [BUS_W-1:0] dm_rdata;
	bus_word_s pm_wdata;
	bus_word_s dm_wdata;
	flags_s flags_first;
	flags_s flags_second;
	int n_fail = 0;
	int num_checks = 0;
	int cycles = 0;
	localparam instr_s NI = '0;
	localparam xfer_s NX = '0;

	dual_element_simd_datapath dual_element_simd_datapath_i (.CORE_CLK(core_clk), .RSTN(rstn),
		.MODE_CTRL(mode_ctrl), .INSTR(instr), .PM_XFER(pm_xfer), .PM_RDATA(pm_rdata),
		.DM_XFER(dm_xfer), .DM_RDATA(dm_rdata), .PM_WDATA(pm_wdata), .DM_WDATA(dm_wdata),
		.FLAGS_FIRST(flags_first), .FLAGS_SECOND(flags_second), .ACTIVE_MODE(active_mode));
	mem_partner mem_partner_i (.clk(core_clk), .rstn(rstn), .pm_x(pm_xfer), .dm_x(dm_xfer),
		.pm_w(pm_wdata), .dm_w(dm_wdata), .pm_r(pm_rdata), .dm_r(dm_rdata));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// Hang guard, well above the roughly 80 cycles the tests need
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input logic [BUS_W:0] seen, input logic [BUS_W:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	function automatic instr_s ins(fmt_e f, alu_op_e a, mul_op_e m, sh_op_e s);
		return '{1'b1, f, '{a, 4'h2, 4'h0, 4'h1}, '{m, 4'h3, 4'h0, 4'h1}, '{s, 4'h4, 4'h0, 4'h1}};
	endfunction

	function automatic xfer_s ld(reg_idx_t k);
		return '{1'b1, 1'b0, k};
	endfunction

	function automatic xfer_s st(reg_idx_t k);
		return '{1'b1, 1'b1, k};
	endfunction

	// One edge of stimulus; every input except reset is assigned exactly once per edge
	task automatic cyc(input instr_s i, input xfer_s p, input xfer_s d);
		@(posedge core_clk);
		instr <= i;
		pm_xfer <= p;
		dm_xfer <= d;
		mode_ctrl <= mode_v;
	endtask

	// Memory words for the next loads; non-blocking so the edge just taken is unaffected
	task automatic load(input logic [63:0] vp, input logic [63:0] vd, input xfer_s p, input xfer_s d);
		mem_partner_i.mem[p.idx] <= vp;
		mem_partner_i.mem[d.idx] <= vd;
		cyc(NI, p, d);
	endtask

	task automatic store(input xfer_s p, input xfer_s d, input logic [63:0] ep, input logic [63:0] ed);
		cyc(NI, p, d);
		cyc(NI, NX, NX);
		#1;
		if (p.valid) check(pm_wdata, {1'b1, ep}, "pm store");
		if (d.valid) check(dm_wdata, {1'b1, ed}, "dm store");
	endtask

	task automatic set_mode(input logic en, input logic sec);
		mode_v = '{en, sec};
		cyc(NI, NX, NX);
		cyc(NI, NX, NX);
		#1;
		check(65'(active_mode), {63'h0, en, sec}, "mode");
	endtask

	function automatic logic [31:0] alu_exp(alu_op_e o, logic [31:0] a, logic [31:0] b);
		case (o)
			ALU_ADD: return a + b;
			ALU_SUB: return a - b;
			ALU_AND: return a & b;
			ALU_OR: return a | b;
			ALU_XOR: return a ^ b;
			ALU_NEG: return -a;
			default: return a;
		endcase
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_single();
		check(65'(active_mode), 65'h0, "reset mode");
		load(64'hfedc_ba98_7654_3210, 64'h0, ld(1), NX);
		cyc(ins(FMT_FIXED, ALU_NEG, MUL_MUL, SH_NOP), NX, NX);
		store(st(1), st(1), 64'h98_7654_3210, 64'h98_7654_3210);
		check(65'(flags_first), 65'h8, "first zero");
		check(65'(flags_second), 65'h0, "second idle");
		$display("test single done");
	endtask

	task automatic t_simd();
		set_mode(1'b1, 1'b0);
		load(64'h1111_2222_3333_4444, 64'h0, ld(6), NX);
		store(st(6), st(6), 64'h1111_2222_3333_4444, 64'h1111_2222_3333_4444);
		set_mode(1'b0, 1'b0);
		load(64'h00aa_bbcc_dd00, 64'h0, ld(6), NX);
		set_mode(1'b1, 1'b0);
		store(st(6), NX, 64'h1111_2222_aabb_ccdd, 64'h0);
		$display("test simd done");
	endtask

	task automatic t_compute();
		alu_op_e o;
		load(64'h0000_0100_0000_0005, 64'h0000_0007_0000_0005, ld(0), ld(1));
		for (int k = 1; k < 9; k++) begin
			o = alu_op_e'(k);
			cyc(ins(FMT_FIXED, o, MUL_MUL, SH_LSH), NX, NX);
			store(st(2), st(3), {alu_exp(o, 32'h100, 32'h7), alu_exp(o, 32'h5, 32'h5)},
				64'h0000_0700_0000_0019);
			if (o == ALU_SUB) begin
				check({61'h0, flags_first.zero, flags_second.zero, 2'h0}, 65'h8, "zero");
			end
		end
		store(st(4), NX, 64'h0000_8000_0000_00a0, 64'h0);
		$display("test compute done");
	endtask

	task automatic t_formats();
		load(64'h4040_0000_4000_0000, 64'h4040_0000_4040_0000, ld(0), ld(1));
		cyc(ins(FMT_SINGLE, ALU_ADD, MUL_MUL, SH_NOP), NX, NX);
		store(st(2), st(3), 64'h40c0_0000_40a0_0000, 64'h4110_0000_40c0_0000);
		set_mode(1'b0, 1'b0);
		load(64'h3f_8000_0002, 64'h3f_8000_0000, ld(0), ld(1));
		cyc(ins(FMT_EXT, ALU_ADD, MUL_MUL, SH_NOP), NX, NX);
		store(st(2), st(3), 64'h40_0000_0001, 64'h3f_8000_0002);
		// Arithmetic right shift by a negative amount keeps the sign
		load(64'h80_0000_0000, 64'h00_0000_fc00, ld(0), ld(1));
		cyc(ins(FMT_FIXED, ALU_NOP, MUL_NOP, SH_ASH), NX, NX);
		store(st(4), NX, 64'hf8_0000_0000, 64'h0);
		$display("test formats done");
	endtask

	task automatic t_banks();
		load(64'h11_2233_4400, 64'h0, ld(7), NX);
		set_mode(1'b0, 1'b1);
		load(64'h55_6677_8800, 64'h66_0000_0100, ld(7), ld(2));
		cyc(ins(FMT_FIXED, ALU_ADD, MUL_MUL, SH_NOP), ld(3), ld(2));
		store(st(2), st(3), 64'h66_0000_0100, 64'h3f_8000_0002);
		set_mode(1'b0, 1'b0);
		store(st(7), NX, 64'h11_2233_4400, 64'h0);
		set_mode(1'b0, 1'b1);
		// Data bus load alone into the secondary bank
		load(64'h0, 64'h77_0000_0200, NX, ld(5));
		store(st(7), st(5), 64'h55_6677_8800, 64'h77_0000_0200);
		$display("test banks done");
	endtask

	// Main sequence: reset held for 8 cycles, then the scenarios in turn
	initial begin
		rstn = 1'b0;
		mode_v = MODE_RESET;
		mode_ctrl = MODE_RESET;
		instr = NI;
		pm_xfer = NX;
		dm_xfer = NX;
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		#1;
		t_single();
		t_simd();
		t_compute();
		t_formats();
		t_banks();
		complete_run();
	end
endmodule
